// ===== shared/exposure_timing_pkg.sv
// Package: constants, enums and carriers of the exposure timing sequencer
package exposure_timing_pkg;

  // Register byte offsets
  localparam logic [7:0] ctrl_offset = 8'h00;
  localparam logic [7:0] frames_offset = 8'h04;
  localparam logic [7:0] exposure_offset = 8'h08;
  localparam logic [7:0] comp_offset = 8'h0c;
  localparam logic [7:0] readout_offset = 8'h10;
  localparam logic [7:0] shift_offset = 8'h14;
  localparam logic [7:0] cmd_offset = 8'h18;
  localparam logic [7:0] status_offset = 8'h1c;
  localparam logic [7:0] clean_rows_offset = 8'h20;

  // Control register field positions
  localparam int ctrl_timing_lsb = 0;
  localparam int ctrl_shutter_lsb = 2;
  localparam int ctrl_edge_lsb = 5;
  localparam int ctrl_safe_bit = 7;
  localparam int ctrl_clean_bit = 8;

  // Command register bits
  localparam int cmd_begin_bit = 0;
  localparam int cmd_halt_bit = 1;

  // Reset values
  localparam logic [31:0] ctrl_reset = 32'h0000_0000;
  localparam logic [31:0] frames_reset = 32'h0000_0001;
  localparam logic [31:0] exposure_reset = 32'h0000_0064;
  localparam logic [31:0] comp_reset = 32'h0000_0010;
  localparam logic [31:0] readout_reset = 32'h0000_0100;
  localparam logic [31:0] shift_reset = 32'h0000_0004;
  localparam logic [31:0] clean_rows_reset = 32'h0000_0010;

  // Timing: least vertical shift of 1 us at 200 MHz
  localparam int clk_mhz = 200;
  localparam int min_shift_us = 1;
  localparam int min_shift_cycles = min_shift_us * clk_mhz;

  typedef enum logic [1:0] {
    timing_freerun = 2'b00,
    timing_ext_sync = 2'b01,
    timing_soft_trig = 2'b10
  } timing_mode_t;

  typedef enum logic [2:0] {
    shutter_normal = 3'b000,
    shutter_preopen = 3'b001,
    shutter_dis_open = 3'b010,
    shutter_dis_closed = 3'b011
  } shutter_mode_t;

  typedef enum logic [1:0] {
    sync_falling = 2'b00,
    sync_rising = 2'b01,
    sync_high = 2'b10,
    sync_low = 2'b11
  } sync_kind_t;

  typedef enum logic [6:0] {
    st_idle = 7'b000_0001,
    st_std_clean = 7'b000_0010,
    st_wait_sync = 7'b000_0100,
    st_expose = 7'b000_1000,
    st_comp = 7'b001_0000,
    st_readout = 7'b010_0000,
    st_next = 7'b100_0000
  } seq_state_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_resp_t;

  typedef struct packed {
    logic shutter;
    logic not_reading_out_flag;
    logic busy;
  } seq_out_t;

endpackage

// ===== src/sync_trigger_detect.sv
// Sync input synchroniser and edge/level trigger qualifier
`timescale 1ns/1ps
`default_nettype none
module sync_trigger_detect (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Pin and selection
  input wire logic sync_pin,
  input wire logic [1:0] kind,
  // Qualified trigger
  output logic trigger
);

  logic meta;
  logic stable;
  logic prev;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta <= 1'b0;
      stable <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= sync_pin;
      stable <= meta;
      prev <= stable;
    end
  end

  // Edge or level qualification
  always_comb begin
    unique case (exposure_timing_pkg::sync_kind_t'(kind))
      exposure_timing_pkg::sync_falling: trigger = prev & ~stable; // see RULE17
      exposure_timing_pkg::sync_rising: trigger = ~prev & stable; // see RULE17
      exposure_timing_pkg::sync_high: trigger = stable; // see RULE17
      exposure_timing_pkg::sync_low: trigger = ~stable; // see RULE17
    endcase
  end

endmodule
`default_nettype wire

// ===== src/exposure_timing_sequencer.sv
// Acquisition timing sequencer with APB registers, shutter and readout status
//
// What this block does
// RULE1: Full speed collects all frames per start
// RULE2: Safe mode stops after every frame
// RULE3: Host restarts only after processing frame
// RULE4: Freerun opens shutter right after readout
// RULE5: Freerun ignores all sync pulses
// RULE6: Normal sync: wait, expose, close, read
// RULE7: Preopen: open when ready, reopen after readout
// RULE8: Preopen only in sync; freerun treats alike
// RULE9: Disabled shutter holds fixed open or closed
// RULE10: Continuous cleans until sync, finish row
// RULE11: Sync during row shift waits shift end
// RULE12: Preopen with cleans stays open throughout
// RULE13: Standard clean always after enable
// RULE14: Not-reading-out flag pulses per clean shift
// RULE15: Trigger leads event by shutter delay
// RULE16: Shutter inhibits pulser during readout
// RULE17: Sync selectable edges or levels
// RULE18: Software trigger runs frame count
// RULE19: Compensation wait before readout
`timescale 1ns/1ps
`default_nettype none
module exposure_timing_sequencer #(
  parameter int cnt_width = 32
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Experiment side
  input wire logic sync_in,
  output logic shutter,
  output logic not_reading_out_flag
);

  if (cnt_width < 8 || cnt_width > 32) begin : g_bad_width
    $error("cnt_width out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  logic [31:0] ctrl;
  logic [31:0] frames_req;
  logic [31:0] exposure_cyc;
  logic [31:0] comp_cyc;
  logic [31:0] readout_cyc;
  logic [31:0] shift_cyc;
  logic [31:0] clean_rows;
  logic begin_capture_cmd;
  logic halt_capture_cmd;
  logic [31:0] frames_done;
  logic wr_en;
  logic rd_en;
  logic addr_ok;

  exposure_timing_pkg::timing_mode_t timing;
  exposure_timing_pkg::shutter_mode_t shut_mode;
  logic safe_mode;
  logic clean_en;

  assign timing = exposure_timing_pkg::timing_mode_t'(ctrl[1:0]);
  assign shut_mode = exposure_timing_pkg::shutter_mode_t'(ctrl[4:2]);
  assign safe_mode = ctrl[exposure_timing_pkg::ctrl_safe_bit];
  assign clean_en = ctrl[exposure_timing_pkg::ctrl_clean_bit];

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a <= exposure_timing_pkg::clean_rows_offset) && (a[1:0] == 2'b00);
  endfunction

  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite & addr_ok;
  assign rd_en = psel & ~penable & ~pwrite;
  assign addr_ok = is_mapped(paddr);
  assign pslverr = psel & penable & ~addr_ok;
  assign begin_capture_cmd = wr_en && paddr == exposure_timing_pkg::cmd_offset
                             && pwdata[exposure_timing_pkg::cmd_begin_bit];
  assign halt_capture_cmd = wr_en && paddr == exposure_timing_pkg::cmd_offset
                            && pwdata[exposure_timing_pkg::cmd_halt_bit];

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl <= exposure_timing_pkg::ctrl_reset;
      frames_req <= exposure_timing_pkg::frames_reset;
      exposure_cyc <= exposure_timing_pkg::exposure_reset;
      comp_cyc <= exposure_timing_pkg::comp_reset;
      readout_cyc <= exposure_timing_pkg::readout_reset;
      shift_cyc <= exposure_timing_pkg::shift_reset;
      clean_rows <= exposure_timing_pkg::clean_rows_reset;
    end else if (wr_en) begin
      unique case (paddr)
        exposure_timing_pkg::ctrl_offset: ctrl <= {23'h00_0000, pwdata[8:0]};
        exposure_timing_pkg::frames_offset: frames_req <= pwdata;
        exposure_timing_pkg::exposure_offset: exposure_cyc <= pwdata;
        exposure_timing_pkg::comp_offset: comp_cyc <= pwdata;
        exposure_timing_pkg::readout_offset: readout_cyc <= pwdata;
        exposure_timing_pkg::shift_offset: shift_cyc <= pwdata;
        exposure_timing_pkg::clean_rows_offset: clean_rows <= pwdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sync input

  logic trig;
  logic trig_latched;
  logic shifting;
  exposure_timing_pkg::seq_state_t state;

  sync_trigger_detect u_sync (
    .core_clk(core_clk),
    .reset(reset),
    .sync_pin(sync_in),
    .kind(ctrl[6:5]),
    .trigger(trig)
  );

  // Trigger caught in wait only in external-sync; freerun never looks
  always_ff @(posedge core_clk) begin
    if (reset) begin
      trig_latched <= 1'b0;
    end else if (state != exposure_timing_pkg::st_wait_sync
                 || timing != exposure_timing_pkg::timing_ext_sync) begin
      trig_latched <= 1'b0; // see RULE5
    end else if (trig) begin
      trig_latched <= 1'b1; // see RULE11
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  logic [31:0] cnt;
  logic [31:0] row_cnt;
  logic [31:0] shift_cnt;
  logic running;
  logic shift_done;
  logic cnt_done;

  assign cnt_done = (cnt <= 32'h0000_0001);
  assign shifting = (shift_cnt != 32'h0000_0000);
  assign shift_done = (shift_cnt == 32'h0000_0001);

  // Row-shift timer used by standard and continuous cleaning
  always_ff @(posedge core_clk) begin
    if (reset) begin
      shift_cnt <= 32'h0000_0000;
    end else if (shifting) begin
      shift_cnt <= shift_cnt - 32'h0000_0001;
    end else if ((state == exposure_timing_pkg::st_std_clean && row_cnt != 32'h0000_0000)
                 || (state == exposure_timing_pkg::st_wait_sync && clean_en
                     && !trig_latched && !trig)) begin
      shift_cnt <= (shift_cnt == 32'h0 && shift_cyc == 32'h0) ? 32'h1 : shift_cyc; // see RULE10
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= exposure_timing_pkg::st_idle;
      cnt <= 32'h0000_0000;
      row_cnt <= 32'h0000_0000;
      frames_done <= 32'h0000_0000;
      running <= 1'b0;
    end else if (halt_capture_cmd) begin
      state <= exposure_timing_pkg::st_idle;
      running <= 1'b0;
    end else begin
      unique case (state)
        exposure_timing_pkg::st_idle: begin
          if (begin_capture_cmd) begin
            running <= 1'b1;
            frames_done <= 32'h0000_0000;
            row_cnt <= clean_rows;
            state <= exposure_timing_pkg::st_std_clean; // see RULE13
          end
        end
        exposure_timing_pkg::st_std_clean: begin
          if (shift_done) begin
            row_cnt <= row_cnt - 32'h0000_0001;
          end
          if (row_cnt == 32'h0000_0000 && !shifting) begin
            if (timing == exposure_timing_pkg::timing_ext_sync) begin
              state <= exposure_timing_pkg::st_wait_sync;
            end else begin
              cnt <= exposure_cyc; // see RULE4
              state <= exposure_timing_pkg::st_expose; // see RULE18
            end
          end
        end
        exposure_timing_pkg::st_wait_sync: begin
          // A pending trigger waits for the row shift to end
          if ((trig_latched || trig) && (!shifting || shift_done)) begin // see RULE11
            cnt <= exposure_cyc;
            state <= exposure_timing_pkg::st_expose; // see RULE6
          end
        end
        exposure_timing_pkg::st_expose: begin
          cnt <= cnt - 32'h0000_0001;
          if (cnt_done) begin
            cnt <= comp_cyc;
            state <= exposure_timing_pkg::st_comp;
          end
        end
        exposure_timing_pkg::st_comp: begin
          cnt <= cnt - 32'h0000_0001;
          if (cnt_done) begin
            cnt <= readout_cyc; // see RULE19
            state <= exposure_timing_pkg::st_readout;
          end
        end
        exposure_timing_pkg::st_readout: begin
          cnt <= cnt - 32'h0000_0001;
          if (cnt_done) begin
            frames_done <= frames_done + 32'h0000_0001;
            state <= exposure_timing_pkg::st_next;
          end
        end
        exposure_timing_pkg::st_next: begin
          if (safe_mode || frames_done >= frames_req) begin
            running <= 1'b0; // see RULE2
            state <= exposure_timing_pkg::st_idle;
          end else if (timing == exposure_timing_pkg::timing_ext_sync) begin
            state <= exposure_timing_pkg::st_wait_sync; // see RULE1
          end else begin
            cnt <= exposure_cyc; // see RULE4
            state <= exposure_timing_pkg::st_expose;
          end
        end
        default: state <= exposure_timing_pkg::st_idle;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  logic next_shutter;
  logic next_nro;
  logic preopen_ok;

  // Preopen only has meaning with external sync
  assign preopen_ok = (shut_mode == exposure_timing_pkg::shutter_preopen)
                      && (timing == exposure_timing_pkg::timing_ext_sync); // see RULE8

  always_comb begin
    next_shutter = 1'b0;
    if (shut_mode == exposure_timing_pkg::shutter_dis_open) begin
      next_shutter = 1'b1; // see RULE9
    end else if (shut_mode == exposure_timing_pkg::shutter_dis_closed) begin
      next_shutter = 1'b0; // see RULE9
    end else if (state == exposure_timing_pkg::st_expose) begin
      next_shutter = 1'b1; // see RULE6
    end else if (preopen_ok && running && state == exposure_timing_pkg::st_wait_sync) begin
      next_shutter = 1'b1; // see RULE7 and RULE12
    end
  end

  // Low during readout and during each cleaning shift
  assign next_nro = !(state == exposure_timing_pkg::st_readout || shifting); // see RULE14

  always_ff @(posedge core_clk) begin
    if (reset) begin
      shutter <= 1'b0;
      not_reading_out_flag <= 1'b1;
    end else begin
      shutter <= next_shutter; // see RULE16
      not_reading_out_flag <= next_nro;
    end
  end

  // Read mux registered in setup phase
  always_ff @(posedge core_clk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (paddr)
        exposure_timing_pkg::ctrl_offset: prdata <= ctrl;
        exposure_timing_pkg::frames_offset: prdata <= frames_req;
        exposure_timing_pkg::exposure_offset: prdata <= exposure_cyc;
        exposure_timing_pkg::comp_offset: prdata <= comp_cyc;
        exposure_timing_pkg::readout_offset: prdata <= readout_cyc;
        exposure_timing_pkg::shift_offset: prdata <= shift_cyc;
        exposure_timing_pkg::status_offset: prdata <= {frames_done[23:0], state, running};
        exposure_timing_pkg::clean_rows_offset: prdata <= clean_rows;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  a_freerun_ignores_sync: assert property (@(posedge core_clk) disable iff (reset)
    timing != exposure_timing_pkg::timing_ext_sync |-> !trig_latched) // see RULE5
    else $error("trigger latched outside external sync");

  a_disabled_open_fixed: assert property (@(posedge core_clk) disable iff (reset)
    $past(shut_mode) == exposure_timing_pkg::shutter_dis_open
    && shut_mode == exposure_timing_pkg::shutter_dis_open |-> shutter) // see RULE9
    else $error("disabled-open shutter dropped");

  a_disabled_closed_fixed: assert property (@(posedge core_clk) disable iff (reset)
    $past(shut_mode) == exposure_timing_pkg::shutter_dis_closed
    && shut_mode == exposure_timing_pkg::shutter_dis_closed |-> !shutter) // see RULE9
    else $error("disabled-closed shutter raised");

  a_readout_shutter_low: assert property (@(posedge core_clk) disable iff (reset)
    state == exposure_timing_pkg::st_readout && $past(state) == exposure_timing_pkg::st_readout
    && shut_mode inside {exposure_timing_pkg::shutter_normal,
                         exposure_timing_pkg::shutter_preopen} |-> !shutter) // see RULE16
    else $error("shutter open during readout");

  a_safe_stops: assert property (@(posedge core_clk) disable iff (reset)
    state == exposure_timing_pkg::st_next && safe_mode && !halt_capture_cmd
    |=> state == exposure_timing_pkg::st_idle) // see RULE2
    else $error("safe mode did not halt");

  a_comp_before_read: assert property (@(posedge core_clk) disable iff (reset)
    state == exposure_timing_pkg::st_readout && $past(state) != exposure_timing_pkg::st_readout
    && !$past(halt_capture_cmd) |-> $past(state) == exposure_timing_pkg::st_comp) // see RULE19
    else $error("readout without compensation");

  a_start_cleans: assert property (@(posedge core_clk) disable iff (reset)
    state == exposure_timing_pkg::st_idle && begin_capture_cmd && !halt_capture_cmd
    |=> state == exposure_timing_pkg::st_std_clean) // see RULE13
    else $error("start skipped standard clean");

  a_shift_flag_low: assert property (@(posedge core_clk) disable iff (reset)
    shifting |=> !not_reading_out_flag) // see RULE14
    else $error("flag not low during shift");

  a_wait_on_shift: assert property (@(posedge core_clk) disable iff (reset)
    state == exposure_timing_pkg::st_wait_sync && shifting && !shift_done
    && !halt_capture_cmd |=> state == exposure_timing_pkg::st_wait_sync) // see RULE11
    else $error("sync acted mid shift");

  c_full_speed_run: cover property (@(posedge core_clk) disable iff (reset)
    state == exposure_timing_pkg::st_next && !safe_mode ##1
    state == exposure_timing_pkg::st_expose);
  c_sync_frame: cover property (@(posedge core_clk) disable iff (reset)
    state == exposure_timing_pkg::st_wait_sync ##1 state == exposure_timing_pkg::st_expose);
  c_preopen_wait: cover property (@(posedge core_clk) disable iff (reset)
    preopen_ok && shutter && state == exposure_timing_pkg::st_wait_sync && shifting);

endmodule
`default_nettype wire

// ===== verif/trig_source.sv
// Behavioural experiment trigger source driving the sync pin
`timescale 1ns/1ps
`default_nettype none
module trig_source (
  // Clock
  input wire logic core_clk,
  // Polarity chosen by the bench
  input wire logic active_high,
  // Pin
  output logic sync_in
);
  ////////////////////////////////////////
  logic firing = 1'b0;

  // Idle is the inverse of the active level, never a stale value
  assign sync_in = firing ? active_high : ~active_high;

  // Pulse placed a lead time ahead of the optical event
  task automatic fire(input int lead, input int width);
    repeat (lead) @(posedge core_clk);
    firing <= 1'b1;
    repeat (width) @(posedge core_clk);
    firing <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench of the exposure timing sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [31:0] exp_c = 32'h0000_0008;
  localparam logic [31:0] rd_c = 32'h0000_0010;
  logic core_clk, reset, psel, penable, pwrite, pready, pslverr;
  logic sync_in, shutter, not_reading_out_flag, act_hi, sh_q, nr_q, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  int errors, cmp_count, rises, falls, sh_run, sh_len, nr_run, nr_len, nr_falls, r0, f0, n0;

  exposure_timing_sequencer #(.cnt_width(32)) i_exposure_timing_sequencer (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_in(sync_in), .shutter(shutter), .not_reading_out_flag(not_reading_out_flag));
  trig_source i_trig_source (.core_clk(core_clk), .active_high(act_hi), .sync_in(sync_in));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////
  // Shutter and readout-flag monitor
  always @(posedge core_clk) begin
    if (shutter === 1'b1 && sh_q === 1'b0) rises <= rises + 1;
    if (shutter === 1'b0 && sh_q === 1'b1) begin
      falls <= falls + 1;
      sh_len <= sh_run;
    end
    sh_run <= (shutter === 1'b1) ? sh_run + 1 : 0;
    if (not_reading_out_flag === 1'b0 && nr_q === 1'b1) nr_falls <= nr_falls + 1;
    if (not_reading_out_flag === 1'b1 && nr_q === 1'b0) nr_len <= nr_run;
    nr_run <= (not_reading_out_flag === 1'b0) ? nr_run + 1 : 0;
    sh_q <= shutter;
    nr_q <= not_reading_out_flag;
  end

  ////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run_wait();
    int n;
    n = 0;
    repeat (3) @(posedge core_clk);
    do begin
      apb(1'b0, exposure_timing_pkg::status_offset, 32'h0000_0000);
      n++;
    end while (rdat[0] !== 1'b0 && n < 300);
    if (n >= 300) chk("run end", 32'h0000_0000, 32'h0000_0001);
  endtask

  task automatic go(input logic [31:0] ctrl, input logic [31:0] frames);
    apb(1'b1, exposure_timing_pkg::ctrl_offset, ctrl);
    apb(1'b1, exposure_timing_pkg::frames_offset, frames);
    r0 = rises;
    f0 = falls;
    n0 = nr_falls;
    apb(1'b1, exposure_timing_pkg::cmd_offset, 32'h0000_0001);
  endtask

  ////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] a[7];
    logic [31:0] v[7];
    a = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
    v = '{exposure_timing_pkg::ctrl_reset, exposure_timing_pkg::frames_reset,
          exposure_timing_pkg::exposure_reset, exposure_timing_pkg::comp_reset,
          exposure_timing_pkg::readout_reset, exposure_timing_pkg::shift_reset,
          exposure_timing_pkg::clean_rows_reset};
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, a[i], 32'h0000_0000);
      chk("reset value", v[i], rdat);
    end
    apb(1'b0, 8'h24, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'h0000_0000, rerr});
    apb(1'b1, exposure_timing_pkg::exposure_offset, exp_c);
    apb(1'b1, exposure_timing_pkg::comp_offset, 32'h0000_0004);
    apb(1'b1, exposure_timing_pkg::readout_offset, rd_c);
    apb(1'b1, exposure_timing_pkg::clean_rows_offset, 32'h0000_0002);
  endtask

  task automatic t_freerun();
    for (int m = 0; m < 2; m++) begin
      go({27'h0000_000, 3'(m), 2'b00}, 32'h0000_0002);
      i_trig_source.fire(10, 4);
      run_wait();
      chk("freerun frames", 32'h0000_0002, 32'(rises - r0));
      chk("exposure len", exp_c, 32'(sh_len));
      chk("readout len", rd_c, 32'(nr_len));
      chk("clean pulses", 32'h0000_0001, 32'(nr_falls - n0 > 2));
      apb(1'b0, exposure_timing_pkg::status_offset, 32'h0000_0000);
      chk("frames done", 32'h0000_0002, rdat >> 8);
    end
  endtask

  task automatic t_safe_soft();
    go(32'h0000_0080, 32'h0000_0003);
    run_wait();
    chk("safe one frame", 32'h0000_0001, 32'(rises - r0));
    apb(1'b1, exposure_timing_pkg::cmd_offset, 32'h0000_0001);
    run_wait();
    chk("safe restart", 32'h0000_0002, 32'(rises - r0));
    go(32'h0000_0002, 32'h0000_0002);
    run_wait();
    chk("soft frames", 32'h0000_0002, 32'(rises - r0));
  endtask

  task automatic t_sync();
    for (int k = 0; k < 4; k++) begin
      act_hi <= (k == 1 || k == 2);
      repeat (8) @(posedge core_clk);
      go({25'h0, 2'(k), 5'h01}, 32'h0000_0001);
      repeat (40) @(posedge core_clk);
      chk("waits for sync", 32'h0000_0000, 32'(rises - r0));
      i_trig_source.fire(0, 4);
      run_wait();
      chk("sync frame", 32'h0000_0001, 32'(rises - r0));
      chk("sync exposure", exp_c, 32'(sh_len));
    end
  endtask

  task automatic t_preopen_clean();
    act_hi <= 1'b0;
    repeat (8) @(posedge core_clk);
    go(32'h0000_0105, 32'h0000_0001);
    repeat (60) @(posedge core_clk);
    chk("preopen open", 32'h0000_0001, {31'h0, shutter});
    chk("cleaning pulses", 32'h0000_0001, 32'(nr_falls - n0 > 6));
    i_trig_source.fire(1, 4);
    run_wait();
    chk("after clean frame", 32'h0000_0000, {31'h0, shutter});
    chk("clean closes once", 32'h0000_0001, 32'(falls - f0));
  endtask

  task automatic t_disabled();
    for (int m = 2; m < 4; m++) begin
      go({27'h0000_000, 3'(m), 2'b00}, 32'h0000_0002);
      repeat (60) @(posedge core_clk);
      chk("held shutter", 32'h0000_0000, 32'(m == 2 ? falls - f0 : rises - r0));
      run_wait();
    end
  endtask

  ////////////////////////////////////////
  task automatic tally_and_finish();
    $display("Comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    #300_000;
    errors++;
    $display("Error watchdog expected finish seen hang");
    tally_and_finish();
  end

  initial begin
    {reset, psel, penable, pwrite, act_hi, sh_q, nr_q} = 7'b1000000;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    {errors, cmp_count, rises, falls, sh_run, sh_len} = '0;
    {nr_run, nr_len, nr_falls} = '0;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    t_regs();
    t_freerun();
    t_safe_soft();
    t_sync();
    t_preopen_clean();
    t_disabled();
    tally_and_finish();
  end
endmodule
`default_nettype wire
